// *** verilog/pmc_phy_mgmt.sv ***
// Purpose: Registers, management slave, interrupt, power and sleep
// Assumes: mdc well below clock_i / 4; pins are asynchronous to clock_i
// Notes:   Line status comes from a Wishbone register
//
// Chosen here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "pmc_cfg.svh"

// Notes on behaviour
// - Sixteen-bit registers, numbered 0 to 31
// - Disable pin high: refuse access, straps rule
// - Answer only frames matching address pins
// - Interrupt pin driven only when 18.1 set
// - Interrupt on negotiation, speed, duplex, link change
// - Causes in register 19, enables in 18
// - Bit 26.11 selects strong data-port drive
// - After reset or link loss, use registers
// - Software mode: straps give defaults, then writes
// - Hardware mode: block writes, straps set registers
// - Forced mode runs at once, else negotiate
// - Power-down pin: stop, tristate, refuse access
// - Bit 0.11 stops port, registers stay accessible
// - Sleep pin enables sleep; 16.6 overrides managed
// - Sleep after 1-3 s without energy
// - Management stays alive during sleep
// - Energy wakes; no link in period, resleep
// - No sleep while fiber selected
// - Bit 0.15 soft reset restores latched advertisement
// - Readable during soft reset; 0.15 self-clears
// - Straps sampled at reset; access after 1 ms
module pmc_phy_mgmt #(
    parameter int ACCESS_WAIT_CYC = `PMC_ACCESS_WAIT_US * `PMC_CLK_MHZ,
    parameter int SLEEP_T1_CYC    = `PMC_SLEEP_T1_US * `PMC_CLK_MHZ,
    parameter int SLEEP_T2_CYC    = `PMC_SLEEP_T2_US * `PMC_CLK_MHZ,
    parameter int SLEEP_T3_CYC    = `PMC_SLEEP_T3_US * `PMC_CLK_MHZ
) (
    input  wire logic        clock_i,                  // 40 MHz
    input  wire logic        sys_rst_i,                // Sync, high
    input  wire logic        wb_cyc_i,                 // Wishbone cycle
    input  wire logic        wb_stb_i,                 // Wishbone strobe
    input  wire logic        wb_we_i,                  // Write
    input  wire logic [3:0]  wb_adr_i,                 // Byte address
    input  wire logic [3:0]  wb_sel_i,                 // Byte lanes
    input  wire logic [31:0] wb_dat_i,                 // Write data
    output logic      [31:0] wb_dat_o,                 // Read data
    output logic             wb_ack_o,                 // Acknowledge
    input  wire logic        mdc_i,                    // Mgmt clock pin
    input  wire logic        mdio_i,                   // Mgmt data in
    output logic             mdio_o,                   // Mgmt data out
    output logic             mdio_oe_n_o,              // Low drives
    input  wire logic [4:0]  phy_address_i,            // Address pins
    input  wire logic        management_disable_pin_i, // High: hw mode
    input  wire logic        hard_power_down_pin_i,    // High: off
    input  wire logic        sleep_pin_i,              // Sleep enable
    input  wire logic [2:0]  strap_cfg_i,              // Config straps
    output logic             interrupt_request_n_o,    // Active low
    output logic             interrupt_request_oe_n_o, // Low drives
    output logic             mii_strong_drive_o,       // Strong drive
    output logic             outputs_tristate_o,       // All pads off
    output logic             pull_disable_o,           // Weak pulls off
    output logic             port_shutdown_o,          // Port stopped
    output logic             an_enable_o,              // Negotiate
    output logic             speed100_o,               // Forced 100
    output logic             full_duplex_o,            // Forced full
    output logic      [3:0]  advertise_o,              // Ability bits
    output logic             link_start_o,             // Start pulse
    output logic             fiber_o,                  // Fiber mode
    output logic             sleeping_o                // In sleep
);

    // Pin synchronisers: first stage is read only by the second
    logic [12:0] sync1;
    logic [12:0] sync2;
    logic        mdc_d, mdc_s, mdio_s, mdis_s, hpd_s, sleep_s;
    logic [4:0]  addr_s;
    logic [2:0]  strap_s;
    assign {strap_s, sleep_s, hpd_s, mdis_s, addr_s, mdio_s, mdc_s} = sync2;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            sync1 <= '0;
            sync2 <= '0;
            mdc_d <= 1'b0;
        end else begin
            sync1 <= {strap_cfg_i, sleep_pin_i, hard_power_down_pin_i,
                      management_disable_pin_i, phy_address_i,
                      mdio_i, mdc_i};
            sync2 <= sync1;
            mdc_d <= mdc_s;
        end
    end

    // Mdc stays at or below 8 MHz, so each edge is seen
    logic mdc_rise;
    assign mdc_rise = mdc_s & ~mdc_d;

    // Access window and strap capture after reset
    logic [15:0] acc_cnt, next_acc_cnt;
    logic        ready, strap_load;
    assign ready      = (acc_cnt == 16'(ACCESS_WAIT_CYC));
    assign strap_load = (acc_cnt == 16'h0003);

    always_comb begin
        next_acc_cnt = ready ? acc_cnt : acc_cnt + 16'h0001;
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) acc_cnt <= '0;
        else           acc_cnt <= next_acc_cnt;
    end

    // Wishbone slave: line status and state readback
    pmc_pkg::pmc_line_t line, next_line, line_d;
    logic        next_ack;
    logic [31:0] next_wb_dat;
    logic [15:0] ctrl, adv, cfg, ien, ist, drv;
    logic [4:0]  sr_cnt;
    logic        sr_busy, access_ok;
    pmc_pkg::pmc_sleep_t sl_st;
    assign sr_busy = (sr_cnt != 5'h00);

    always_comb begin
        next_ack    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
        next_line   = line;
        next_wb_dat = '0;
        if (next_ack) begin
            case (wb_adr_i)
                `PMC_WB_LINE: begin
                    if (wb_we_i && wb_sel_i[0])
                        next_line = pmc_pkg::pmc_line_t'(wb_dat_i[4:0]);
                    next_wb_dat = {27'h0, line};
                end
                `PMC_WB_STATE: begin
                    next_wb_dat = {25'h0, ~interrupt_request_n_o,
                                   mdis_s, ready, sr_busy,
                                   ctrl[`PMC_CTRL_PDOWN], hpd_s,
                                   sl_st == pmc_pkg::SL_ASLEEP};
                end
                default: next_wb_dat = '0;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
            line     <= '0;
        end else begin
            wb_ack_o <= next_ack;
            wb_dat_o <= next_wb_dat;
            line     <= next_line;
        end
    end

    // Serial management frame engine
    pmc_pkg::pmc_frame_t fr_st, next_fr_st;
    logic [5:0]  ones, next_ones;
    logic [3:0]  bit_cnt, next_bit_cnt;
    logic [15:0] shreg, next_shreg;
    logic [4:0]  reg_a, next_reg_a;
    logic        is_read, next_is_read, hit, next_hit;
    logic        drive, next_drive, mdo, next_mdo;
    logic        wr_en, rd_ist;
    logic [15:0] wr_data, rdata;
    logic [12:0] hdr;

    assign access_ok = ~mdis_s & ~hpd_s & ready;
    assign hdr       = {shreg[11:0], mdio_s};

    always_comb begin
        case (reg_a)
            `PMC_REG_CTRL:  rdata = {sr_busy, ctrl[14:0]};
            `PMC_REG_STAT:  rdata = `PMC_STAT_ABILITY
                                  | (16'(line.link_up) << `PMC_STAT_LINK)
                                  | (16'(line.an_done) << `PMC_STAT_AN_DONE);
            `PMC_REG_ADV:   rdata = adv;
            `PMC_REG_CFG:   rdata = cfg;
            `PMC_REG_IEN:   rdata = ien;
            `PMC_REG_ISTAT: rdata = ist;
            `PMC_REG_DRV:   rdata = drv;
            default:        rdata = 16'h0000;
        endcase
    end

    always_comb begin
        next_fr_st   = fr_st;
        next_ones    = ones;
        next_bit_cnt = bit_cnt;
        next_shreg   = shreg;
        next_reg_a   = reg_a;
        next_is_read = is_read;
        next_hit     = hit;
        next_drive   = drive;
        next_mdo     = mdo;
        wr_en        = 1'b0;
        rd_ist       = 1'b0;
        wr_data      = {shreg[14:0], mdio_s};
        if (mdc_rise) begin
            case (fr_st)
                pmc_pkg::FR_PREAMBLE: begin
                    if (mdio_s) begin
                        if (ones != `PMC_PREAMBLE_MIN)
                            next_ones = ones + 6'h01;
                    end else begin
                        if (ones == `PMC_PREAMBLE_MIN) begin
                            next_fr_st   = pmc_pkg::FR_HEADER;
                            next_bit_cnt = '0;
                        end
                        next_ones = '0;
                    end
                end
                pmc_pkg::FR_HEADER: begin
                    next_shreg   = {shreg[14:0], mdio_s};
                    next_bit_cnt = bit_cnt + 4'h1;
                    if (bit_cnt == 4'hc) begin
                        next_bit_cnt = '0;
                        if (hdr[12] && (hdr[11:10] == 2'b10 ||
                                        hdr[11:10] == 2'b01)) begin
                            next_fr_st   = pmc_pkg::FR_TURN;
                            next_is_read = hdr[11];
                            next_reg_a   = hdr[4:0];
                            next_hit     = (hdr[9:5] == addr_s)
                                         & access_ok;
                        end else begin
                            next_fr_st = pmc_pkg::FR_PREAMBLE;
                        end
                    end
                end
                pmc_pkg::FR_TURN: begin
                    if (bit_cnt == 4'h0) begin
                        next_bit_cnt = 4'h1;
                        next_drive   = is_read & hit;
                        next_mdo     = 1'b0;
                    end else begin
                        next_fr_st   = pmc_pkg::FR_DATA;
                        next_bit_cnt = '0;
                        if (is_read && hit) begin
                            next_shreg = {rdata[14:0], 1'b0};
                            next_mdo   = rdata[15];
                            rd_ist     = (reg_a == `PMC_REG_ISTAT);
                        end
                    end
                end
                pmc_pkg::FR_DATA: begin
                    next_bit_cnt = bit_cnt + 4'h1;
                    if (is_read) begin
                        next_mdo   = shreg[15];
                        next_shreg = {shreg[14:0], 1'b0};
                    end else begin
                        next_shreg = {shreg[14:0], mdio_s};
                    end
                    if (bit_cnt == 4'hf) begin
                        next_fr_st = pmc_pkg::FR_PREAMBLE;
                        next_drive = 1'b0;
                        next_mdo   = 1'b0;
                        wr_en      = ~is_read & hit & access_ok;
                    end
                end
                default: next_fr_st = pmc_pkg::FR_PREAMBLE;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            fr_st   <= pmc_pkg::FR_PREAMBLE;
            ones    <= '0;
            bit_cnt <= '0;
            shreg   <= '0;
            reg_a   <= '0;
            is_read <= 1'b0;
            hit     <= 1'b0;
            drive   <= 1'b0;
            mdo     <= 1'b0;
        end else begin
            fr_st   <= next_fr_st;
            ones    <= next_ones;
            bit_cnt <= next_bit_cnt;
            shreg   <= next_shreg;
            reg_a   <= next_reg_a;
            is_read <= next_is_read;
            hit     <= next_hit;
            drive   <= next_drive;
            mdo     <= next_mdo;
        end
    end

    // Management registers
    logic [15:0] next_ctrl, next_adv, next_cfg, next_ien, next_ist;
    logic [15:0] next_drv, ctrl_hw, adv_hw, next_ctrl_hw, next_adv_hw;
    logic [15:0] strap_ctrl, strap_adv;
    logic [4:0]  next_sr_cnt;
    logic [3:0]  ev;
    logic        next_start;

    // Straps are {an, speed, duplex}
    always_comb begin
        strap_ctrl = 16'h0000;
        strap_ctrl[`PMC_CTRL_ANEN]  = strap_s[2];
        strap_ctrl[`PMC_CTRL_SPEED] = strap_s[2] | strap_s[1];
        strap_ctrl[`PMC_CTRL_FDX]   = strap_s[2] ? (strap_s[0] | ~strap_s[1])
                                                 : strap_s[0];
        case (strap_s)
            3'b100:  strap_adv = `PMC_ADV_SELECTOR | 16'h0080;
            3'b101:  strap_adv = `PMC_ADV_SELECTOR | 16'h0180;
            3'b110:  strap_adv = `PMC_ADV_SELECTOR | 16'h00a0;
            default: strap_adv = `PMC_ADV_SELECTOR | 16'h01e0;
        endcase
    end

    assign ev = {line.link_up ^ line_d.link_up,
                 line.full_duplex ^ line_d.full_duplex,
                 line.speed100 ^ line_d.speed100,
                 line.an_done & ~line_d.an_done};

    always_comb begin
        next_ctrl    = ctrl;
        next_adv     = adv;
        next_cfg     = cfg;
        next_ien     = ien;
        next_drv     = drv;
        next_ctrl_hw = ctrl_hw;
        next_adv_hw  = adv_hw;
        next_sr_cnt  = sr_busy ? sr_cnt - 5'h01 : sr_cnt;
        next_start   = (sr_cnt == 5'h01)
                     | (line_d.link_up & ~line.link_up);
        // Clear on read first, so a same-cycle event still lands
        next_ist = (rd_ist ? 16'h0000 : ist)
                 | (16'(ev) << `PMC_EV_LSB);
        if (strap_load) begin
            next_ctrl    = strap_ctrl;
            next_adv     = strap_adv;
            next_ctrl_hw = strap_ctrl;
            next_adv_hw  = strap_adv;
            next_cfg[`PMC_CFG_SLEEP] = sleep_s;
            next_start   = 1'b1;
        end else if (mdis_s) begin
            next_ctrl = strap_ctrl;
            next_adv  = strap_adv;
        end else if (sr_busy) begin
            next_ctrl = ctrl_hw;
            next_adv  = adv_hw;
            next_cfg  = `PMC_CFG_RESET;
            next_ien  = `PMC_IEN_RESET;
            next_drv  = `PMC_DRV_RESET;
        end else if (wr_en) begin
            case (reg_a)
                `PMC_REG_CTRL: begin
                    next_ctrl = wr_data;
                    next_ctrl[`PMC_CTRL_RESET] = 1'b0;
                    if (wr_data[`PMC_CTRL_RESET])
                        next_sr_cnt = `PMC_SRST_CYCLES;
                    else
                        next_start = 1'b1;
                end
                `PMC_REG_ADV: next_adv = wr_data;
                `PMC_REG_CFG: next_cfg = wr_data;
                `PMC_REG_IEN: next_ien = wr_data;
                `PMC_REG_DRV: next_drv = wr_data;
                default:      next_ctrl = ctrl;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            ctrl         <= 16'h0000;
            adv          <= `PMC_ADV_SELECTOR;
            cfg          <= `PMC_CFG_RESET;
            ien          <= `PMC_IEN_RESET;
            ist          <= 16'h0000;
            drv          <= `PMC_DRV_RESET;
            ctrl_hw      <= 16'h0000;
            adv_hw       <= `PMC_ADV_SELECTOR;
            sr_cnt       <= '0;
            line_d       <= '0;
            link_start_o <= 1'b0;
        end else begin
            ctrl         <= next_ctrl;
            adv          <= next_adv;
            cfg          <= next_cfg;
            ien          <= next_ien;
            ist          <= next_ist;
            drv          <= next_drv;
            ctrl_hw      <= next_ctrl_hw;
            adv_hw       <= next_adv_hw;
            sr_cnt       <= next_sr_cnt;
            line_d       <= line;
            link_start_o <= next_start;
        end
    end

    // Energy-detect sleep
    pmc_pkg::pmc_sleep_t next_sl_st;
    logic [26:0] sl_cnt, next_sl_cnt, sl_limit;
    logic        sleep_en;

    always_comb begin
        case (cfg[4:3])
            2'b01:   sl_limit = 27'(SLEEP_T2_CYC);
            2'b10, 2'b11: sl_limit = 27'(SLEEP_T1_CYC);
            default: sl_limit = 27'(SLEEP_T3_CYC);
        endcase
    end

    // Managed mode lets 16.6 stand in for the pin; fiber never sleeps
    assign sleep_en = (mdis_s ? sleep_s : cfg[`PMC_CFG_SLEEP])
                    & ~cfg[`PMC_CFG_FIBER];

    always_comb begin
        next_sl_st  = sl_st;
        next_sl_cnt = sl_cnt + 27'h1;
        case (sl_st)
            pmc_pkg::SL_AWAKE: begin
                if (!sleep_en || line.energy) begin
                    next_sl_cnt = '0;
                end else if (sl_cnt >= sl_limit) begin
                    next_sl_st  = pmc_pkg::SL_ASLEEP;
                    next_sl_cnt = '0;
                end
            end
            pmc_pkg::SL_ASLEEP: begin
                next_sl_cnt = '0;
                if (!sleep_en)
                    next_sl_st = pmc_pkg::SL_AWAKE;
                else if (line.energy)
                    next_sl_st = pmc_pkg::SL_CHECK;
            end
            pmc_pkg::SL_CHECK: begin
                if (!sleep_en || line.link_up) begin
                    next_sl_st  = pmc_pkg::SL_AWAKE;
                    next_sl_cnt = '0;
                end else if (sl_cnt >= sl_limit) begin
                    next_sl_st  = pmc_pkg::SL_ASLEEP;
                    next_sl_cnt = '0;
                end
            end
            default: begin
                next_sl_st  = pmc_pkg::SL_AWAKE;
                next_sl_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            sl_st  <= pmc_pkg::SL_AWAKE;
            sl_cnt <= '0;
        end else begin
            sl_st  <= next_sl_st;
            sl_cnt <= next_sl_cnt;
        end
    end

    // Outputs; sleep leaves the frame engine running
    assign sleeping_o  = (sl_st == pmc_pkg::SL_ASLEEP);
    assign mdio_o      = mdo;
    assign mdio_oe_n_o = ~drive | hpd_s | mdis_s;
    assign interrupt_request_n_o = ~(ien[`PMC_IEN_ENABLE]
                                   & |(ist & ien));
    assign interrupt_request_oe_n_o = ~ien[`PMC_IEN_ENABLE] | hpd_s;
    assign mii_strong_drive_o = drv[`PMC_DRV_STRONG];
    assign outputs_tristate_o = hpd_s;
    assign pull_disable_o     = hpd_s;
    assign port_shutdown_o    = hpd_s | ctrl[`PMC_CTRL_PDOWN]
                              | sleeping_o;
    assign an_enable_o   = ctrl[`PMC_CTRL_ANEN];
    assign speed100_o    = ctrl[`PMC_CTRL_SPEED];
    assign full_duplex_o = ctrl[`PMC_CTRL_FDX];
    assign advertise_o   = adv[8:5];
    assign fiber_o       = cfg[`PMC_CFG_FIBER];

endmodule

// *** include/pmc_cfg.svh ***
// Purpose: Constants for the PHY management control block
// Assumes: 40 MHz system clock
// Notes:   Times in microseconds
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

`define PMC_CLK_MHZ        40
`define PMC_ACCESS_WAIT_US 1000
`define PMC_SLEEP_T1_US    1040000
`define PMC_SLEEP_T2_US    2040000
`define PMC_SLEEP_T3_US    3040000
`define PMC_SRST_CYCLES    5'h10
`define PMC_PREAMBLE_MIN   6'h20

`define PMC_REG_CTRL       5'h00
`define PMC_REG_STAT       5'h01
`define PMC_REG_ADV        5'h04
`define PMC_REG_CFG        5'h10
`define PMC_REG_IEN        5'h12
`define PMC_REG_ISTAT      5'h13
`define PMC_REG_DRV        5'h1a

`define PMC_CTRL_RESET     15
`define PMC_CTRL_SPEED     13
`define PMC_CTRL_ANEN      12
`define PMC_CTRL_PDOWN     11
`define PMC_CTRL_FDX       8
`define PMC_CFG_SLEEP      6
`define PMC_CFG_FIBER      0
`define PMC_IEN_ENABLE     1
`define PMC_EV_LSB         4
`define PMC_DRV_STRONG     11
`define PMC_STAT_LINK      2
`define PMC_STAT_AN_DONE   5

`define PMC_STAT_ABILITY   16'h7808
`define PMC_CFG_RESET      16'h0000
`define PMC_IEN_RESET      16'h0000
`define PMC_DRV_RESET      16'h0000
`define PMC_ADV_SELECTOR   16'h0001

`define PMC_WB_LINE        4'h0
`define PMC_WB_STATE       4'h4

`endif

// *** include/pmc_pkg.sv ***
// Purpose: Types for the PHY management control block
// Assumes: Constants come from pmc_cfg.svh
// Notes:   Types only
package pmc_pkg;

    typedef struct packed {
        logic energy;
        logic an_done;
        logic full_duplex;
        logic speed100;
        logic link_up;
    } pmc_line_t;

    typedef enum logic [1:0] {
        FR_PREAMBLE,
        FR_HEADER,
        FR_TURN,
        FR_DATA
    } pmc_frame_t;

    typedef enum logic [1:0] {
        SL_AWAKE,
        SL_ASLEEP,
        SL_CHECK
    } pmc_sleep_t;

endpackage

// *** verif/pmc_phy_mgmt_monitor.sv ***
// Purpose: Port assertions for pmc_phy_mgmt
// Assumes: Pin synchroniser lag of two cycles
// Notes:   Bound to every instance
`timescale 1ns/1ps
module pmc_phy_mgmt_monitor (
    input wire logic clock_i,                  // Clock
    input wire logic sys_rst_i,                // Reset
    input wire logic management_disable_pin_i, // Hw mode
    input wire logic mdio_oe_n_o,              // Data drive
    input wire logic outputs_tristate_o,       // Pads off
    input wire logic pull_disable_o,           // Pulls off
    input wire logic port_shutdown_o,          // Port off
    input wire logic link_start_o,             // Start
    input wire logic fiber_o,                  // Fiber
    input wire logic sleeping_o                // Asleep
);
    default clocking dc @(posedge clock_i);
    endclocking
    default disable iff (sys_rst_i);
    pd_pull_a: assert property (
        outputs_tristate_o == pull_disable_o) else $error("pulls on");
    pd_port_a: assert property (
        outputs_tristate_o |-> port_shutdown_o) else $error("port on");
    pd_mdio_a: assert property (
        outputs_tristate_o [*2] |-> mdio_oe_n_o) else $error("mdio on");
    sleep_port_a: assert property (
        sleeping_o |-> port_shutdown_o) else $error("port on asleep");
    fiber_sleep_a: assert property (
        $rose(sleeping_o) |-> !$past(fiber_o)) else $error("fiber sleep");
    start_pulse_a: assert property (
        link_start_o |=> !link_start_o) else $error("long start");
    boot_quiet_a: assert property (
        $fell(sys_rst_i) |-> mdio_oe_n_o [*8]) else $error("early drive");
    mdis_quiet_a: assert property (
        management_disable_pin_i [*6] |-> mdio_oe_n_o) else $error("drive");
    sleep_c: cover property (sleeping_o);
    start_c: cover property (link_start_o);
    drive_c: cover property (!mdio_oe_n_o);
endmodule

bind pmc_phy_mgmt pmc_phy_mgmt_monitor mon_u (.clock_i, .sys_rst_i,
    .management_disable_pin_i, .mdio_oe_n_o, .outputs_tristate_o,
    .pull_disable_o, .port_shutdown_o, .link_start_o, .fiber_o, .sleeping_o);

// *** verif/pmc_smc_model.sv ***
// Purpose: Station management controller model
// Assumes: Pull-up on the data line
// Notes:   Clock stands low between frames
`timescale 1ns/1ps
module pmc_smc_model (
    input  wire logic        clock_i,    // Bench clock
    input  wire logic        dev_dat_i,  // Device data
    input  wire logic        dev_oe_n_i, // Device drives
    output logic             mdc_o,      // Mgmt clock
    output logic             line_o,     // Data line
    output logic             done_o,     // Read done
    output logic      [15:0] q_o         // Read data
);
    logic en = 1'b0;
    logic val = 1'b1;
    assign line_o = !dev_oe_n_i ? dev_dat_i : (en ? val : 1'b1);
    initial begin
        mdc_o = 1'b0;
        done_o = 1'b0;
    end
    task automatic xfer(input logic rd, input logic [4:0] pa, ra,
                        input logic [15:0] wd);
        logic [63:0] f;
        f = {32'hffffffff, 2'h1, rd, !rd, pa, ra, 2'h2, wd};
        for (int i = 63; i >= 0; i--) begin
            en <= !rd || i > 17;
            val <= f[i];
            repeat (4) @(posedge clock_i);
            mdc_o <= 1'b1; // 200 ns period
            q_o <= {q_o[14:0], line_o};
            repeat (4) @(posedge clock_i);
            mdc_o <= 1'b0;
        end
        en <= 1'b0;
        done_o <= rd;
        @(posedge clock_i);
        done_o <= 1'b0;
    endtask
endmodule

// *** verif/pmc_phy_mgmt_tb_top.sv ***
// Purpose: Self-checking bench for pmc_phy_mgmt
// Assumes: Short wait and sleep counts
// Notes:   Reads noted in a queue, matched on answer
`timescale 1ns/1ps
module pmc_phy_mgmt_tb_top;
    logic clock_i, wb_ack_o, mdc_i, mdio_i, mdio_o, mdio_oe_n_o, done;
    logic sys_rst_i = 1'b1, wb_cyc_i = 1'b0, wb_we_i = 1'b0;
    logic management_disable_pin_i = 1'b0, hard_power_down_pin_i = 1'b0;
    logic sleep_pin_i = 1'b0, interrupt_request_n_o, interrupt_request_oe_n_o;
    logic mii_strong_drive_o, outputs_tristate_o, sleeping_o;
    logic [1:0] irq;
    logic [2:0] strap_cfg_i = 3'h3;
    logic [3:0] wb_adr_i = 4'h0;
    logic [4:0] phy_address_i;
    logic [15:0] q;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, exp_q[$];
    int bad_count, checked;
    assign irq = {interrupt_request_oe_n_o, interrupt_request_n_o};
    pmc_smc_model smc_u (.clock_i, .dev_dat_i(mdio_o),
        .dev_oe_n_i(mdio_oe_n_o), .mdc_o(mdc_i), .line_o(mdio_i),
        .done_o(done), .q_o(q));
    pmc_phy_mgmt #(.ACCESS_WAIT_CYC(50), .SLEEP_T1_CYC(100),
        .SLEEP_T2_CYC(200), .SLEEP_T3_CYC(300)) dut_u (.clock_i,
        .sys_rst_i, .wb_cyc_i, .wb_stb_i(wb_cyc_i), .wb_we_i, .wb_adr_i,
        .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .mdc_i, .mdio_i,
        .mdio_o, .mdio_oe_n_o, .phy_address_i, .management_disable_pin_i,
        .hard_power_down_pin_i, .sleep_pin_i, .strap_cfg_i,
        .interrupt_request_n_o, .interrupt_request_oe_n_o,
        .mii_strong_drive_o, .outputs_tristate_o, .pull_disable_o(),
        .port_shutdown_o(), .an_enable_o(), .speed100_o(), .fiber_o(),
        .full_duplex_o(), .advertise_o(), .link_start_o(), .sleeping_o);
    task automatic chk(input string n, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic end_sim;
        if (bad_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wb(input logic we, input logic [3:0] a,
                      input logic [31:0] d);
        @(posedge clock_i);
        wb_cyc_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clock_i); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
    endtask
    task automatic mrd(input logic [4:0] pa, ra, input logic [15:0] e);
        exp_q.push_back({16'h0, e});
        smc_u.xfer(1'b1, pa, ra, 16'h0);
    endtask
    task automatic mwr(input logic [4:0] ra, input logic [15:0] d);
        smc_u.xfer(1'b0, phy_address_i, ra, d);
    endtask
    always @(posedge clock_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
            chk("wb", wb_dat_o, exp_q.pop_front());
        if (done === 1'b1)
            chk("mdio", {16'h0, q}, exp_q.pop_front());
    end
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end
    initial begin
        repeat (30000) @(posedge clock_i);
        bad_count++;
        end_sim();
    end
    initial begin
        void'($urandom(32'he225a1b3));
        repeat (2) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        phy_address_i <= 5'($urandom);
        exp_q.push_back(32'h0);
        wb(1'b0, 4'h8, 32'h0);
        repeat (60) @(posedge clock_i);
        mrd(phy_address_i, 5'h01, 16'h7808);
        mrd(~phy_address_i, 5'h01, 16'hffff);
        mrd(phy_address_i, 5'h00, 16'h2100);
        strap_cfg_i <= 3'h7;
        mwr(5'h00, 16'h8000);
        mrd(phy_address_i, 5'h00, 16'h2100);
        mwr(5'h1a, 16'h0800);
        chk("drive", 32'(mii_strong_drive_o), 32'h1);
        mrd(phy_address_i, 5'h13, 16'h0000);
        mwr(5'h12, 16'h00f2);
        wb(1'b1, 4'h0, 32'h1);
        repeat (4) @(posedge clock_i);
        chk("irq", 32'(irq), 32'h0);
        mrd(phy_address_i, 5'h13, 16'h0080);
        chk("irq", 32'(irq), 32'h1);
        mwr(5'h12, 16'h0000);
        chk("irq", 32'(irq[1]), 32'h1);
        wb(1'b1, 4'h0, 32'h0);
        mwr(5'h10, 16'h0040);
        sleep_pin_i <= 1'b1;
        repeat (400) @(posedge clock_i);
        chk("sleep", 32'(sleeping_o), 32'h1);
        mrd(phy_address_i, 5'h01, 16'h7808);
        wb(1'b1, 4'h0, 32'h10);
        repeat (4) @(posedge clock_i);
        chk("sleep", 32'(sleeping_o), 32'h0);
        wb(1'b1, 4'h0, 32'h0);
        mwr(5'h10, 16'h0041);
        chk("sleep", 32'(sleeping_o), 32'h0);
        management_disable_pin_i <= 1'b1;
        mrd(phy_address_i, 5'h01, 16'hffff);
        hard_power_down_pin_i <= 1'b1;
        mrd(phy_address_i, 5'h01, 16'hffff);
        end_sim();
    end
endmodule
